/* host_port_model.sv */
// Host side model of the management byte port, standing in for the two-wire engine.
// Assumes each task is entered at a falling edge of mclk; requests change only there.
module host_port_model
  import module_monitor_pkg::*;
(
  input wire logic mclk,
  output host_access_t host_access,
  input wire logic [7:0] host_rdata,
  input wire logic host_rvalid,
  input wire logic host_hit
);
  timeunit 1ns;
  timeprecision 1ps;

  // Quiet bus until the first request
  initial host_access = '0;

  // One byte cycle: held across one rising edge, answer taken where it stands
  task automatic acc(input logic r, input logic w, input logic [7:0] a, input logic [7:0] d,
                     output logic [7:0] q, output logic v, output logic h);
    host_access = '{rd: r, wr: w, addr: a, wdata: d};
    @(negedge mclk);
    q = host_rdata;
    v = host_rvalid;
    h = host_hit;
  endtask
endmodule // host_port_model

/* module_monitor_cfg.svh */
// Offsets, field positions, reset values and timing counts for the module monitor and control bank.
// Assumes byte addressing of the lower management memory as seen by the two-wire engine.
`ifndef MODULE_MONITOR_CFG_SVH
`define MODULE_MONITOR_CFG_SVH

// Byte offsets; every monitor pair starts at its more significant byte
`define OFS_TEMPERATURE 8'h0e
`define OFS_SUPPLY 8'h10
`define OFS_AUX_ONE 8'h12
`define OFS_AUX_TWO 8'h14
`define OFS_AUX_THREE 8'h16
`define OFS_VENDOR 8'h18
`define OFS_GLOBAL_CONTROL 8'h1a
`define OFS_RESERVED_PAIR 8'h1b
`define OFS_VENDOR_CONTROL 8'h1d
`define OFS_LAST 8'h1e

// Global control byte fields
`define GCTL_PIN_ENABLE_BIT 6
`define GCTL_SQUELCH_BIT 5
`define GCTL_SW_LOW_POWER_BIT 4
`define GCTL_SW_RESET_BIT 3
`define GCTL_RESET_VALUE 8'h40
`define GCTL_READ_MASK 8'h70

// Symmetric full-scale limits of the cooler current code
`define TEC_MOST_NEGATIVE 16'h8000
`define TEC_FULL_COOLING 16'h8001

// Reset hold time and clock rate
`define SYS_CLK_MHZ 50
`define RESET_HOLD_NS 10000
`define RESET_HOLD_CYCLES ((`RESET_HOLD_NS * `SYS_CLK_MHZ + 999) / 1000)

`endif

/* module_monitor_control_regs.sv */
// Module level monitor values and global control byte of the management memory.
// Assumes a two-wire engine ahead of it issuing single-cycle byte reads and writes, and
// inputs that are already synchronous to mclk.
//
// How it works
// - Temperature, signed, 1/256 degree steps.
// - Supply voltage, unsigned, 100 microvolt steps.
// - Aux one: custom or cooler current.
// - Aux two: laser temperature or cooler current.
// - Aux three: laser temperature or extra supply.
// - Cooler current symmetric, plus/minus 32767 full scale.
// - Vendor monitor signedness fixed by vendor.
// - Bit 6 gates low power pin.
// - Bit 5 selects squelch kind.
// - Bit 4 software low power request.
// - Bit 3 write-only self-clearing reset trigger.
// - Software reset equals held hardware reset; here it restores control defaults and holds module_reset, monitors kept.
`include "module_monitor_cfg.svh"

module module_monitor_control_regs
  import module_monitor_pkg::*;
#(
  parameter bit AUX_ONE_IS_TEC = 1'b0,
  parameter bit AUX_TWO_IS_TEC = 1'b0,
  parameter bit AUX_THREE_IS_SUPPLY = 1'b0,
  parameter bit VENDOR_IS_SIGNED = 1'b0,
  parameter int RESET_HOLD_CYCLES = `RESET_HOLD_CYCLES
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire host_access_t host_access,
  output logic [7:0] host_rdata,
  output logic host_rvalid,
  output logic host_hit,
  input wire monitor_samples_t samples,
  input wire logic samples_valid,
  input wire logic pin_low_power_request,
  output logic low_power_request,
  output logic squelch_kind_select,
  output logic module_reset
);

  // Number of monitor pairs held in the bank
  localparam int MONITORS = 6;
  // Control byte value after either kind of reset
  localparam logic [7:0] GCTL_DEFAULT = `GCTL_RESET_VALUE;

  // Captured monitor words, index 0 is temperature
  logic [15:0] mon_reg [MONITORS];
  // Sources feeding each monitor word
  logic [15:0] mon_src [MONITORS];
  // Cooler current after clamping to the symmetric range
  logic [15:0] tec_code;

  // Stored global control bits 6..4
  logic pin_low_power_request_enable_reg;
  logic squelch_kind_reg;
  logic register_low_power_request_reg;

  // Reset sequencer
  reset_state_t state_reg, state_next;
  logic [15:0] hold_count_reg, hold_count_next;

  // Low byte held back by a high byte read
  logic [7:0] lsb_hold_reg;
  logic [2:0] hold_index_reg;
  logic hold_valid_reg;

  // Output flops
  logic [7:0] host_rdata_reg;
  logic host_rvalid_reg;
  logic host_hit_reg;
  logic low_power_request_reg;
  logic squelch_kind_select_reg;
  logic module_reset_reg;

  // Address decode
  wire logic in_monitors = (host_access.addr >= `OFS_TEMPERATURE) && (host_access.addr < `OFS_GLOBAL_CONTROL);
  wire logic in_bank = (host_access.addr >= `OFS_TEMPERATURE) && (host_access.addr <= `OFS_LAST);
  wire logic is_gctl = host_access.addr == `OFS_GLOBAL_CONTROL;
  wire logic [7:0] mon_offset = host_access.addr - `OFS_TEMPERATURE;
  wire logic [2:0] mon_index = mon_offset[3:1];
  wire logic is_high_byte = !mon_offset[0];
  wire logic [15:0] mon_word = in_monitors ? mon_reg[mon_index] : 16'h0000;

  // Writes land only while the module is out of reset
  wire logic gctl_write = host_access.wr && is_gctl && (state_reg == RUNNING);
  wire logic reset_trigger = gctl_write && host_access.wdata[`GCTL_SW_RESET_BIT];
  // Held low byte answers a low byte read of the same pair
  wire logic use_hold = hold_valid_reg && (hold_index_reg == mon_index) && !is_high_byte;

  // Read-back of the control byte, trigger and custom bits read as zero
  wire logic [7:0] gctl_read = {1'b0, pin_low_power_request_enable_reg, squelch_kind_reg,
                                register_low_power_request_reg, 4'h0} & `GCTL_READ_MASK;

  // Read data mux: monitors, control byte, reserved and custom bytes read zero
  wire logic [7:0] rdata_next = in_monitors ? (is_high_byte ? mon_word[15:8] :
                                               (use_hold ? lsb_hold_reg : mon_word[7:0])) :
                                (is_gctl ? gctl_read : 8'h00);

  // Pin gated by its enable, combined with the register request
  wire logic lp_next = (pin_low_power_request_enable_reg && pin_low_power_request) ||
                       register_low_power_request_reg;

  // Clamp the one code outside the symmetric scale to full cooling
  assign tec_code = (samples.tec_current == `TEC_MOST_NEGATIVE) ? `TEC_FULL_COOLING :
                    samples.tec_current;

  // Source selection per monitor, fixed by the advertised observable
  assign mon_src[0] = samples.temperature;
  assign mon_src[1] = samples.supply;
  assign mon_src[2] = AUX_ONE_IS_TEC ? tec_code : samples.aux_custom;
  assign mon_src[3] = AUX_TWO_IS_TEC ? tec_code : samples.laser_temperature;
  assign mon_src[4] = AUX_THREE_IS_SUPPLY ? samples.aux_supply : samples.laser_temperature;
  // Vendor word passes untouched; its signedness is the vendor's definition
  assign mon_src[5] = samples.vendor;

  // Monitor capture, one whole word per sample strobe
  for (genvar i = 0; i < MONITORS; i++) begin : g_monitor
    always_ff @(posedge mclk) begin
      if (sys_rst) begin
        mon_reg[i] <= 16'h0000;
      end else if (samples_valid) begin
        mon_reg[i] <= mon_src[i];
      end
    end
  end

  // Reset sequencer next state, trigger starts a full hold period
  always_comb begin
    state_next = state_reg;
    hold_count_next = hold_count_reg;
    unique case (state_reg)
      RUNNING: begin
        if (reset_trigger) begin
          state_next = SOFT_RESET;
          hold_count_next = 16'(RESET_HOLD_CYCLES - 1);
        end
      end
      SOFT_RESET: begin
        if (hold_count_reg == 16'h0000) begin
          state_next = RUNNING;
        end else begin
          hold_count_next = hold_count_reg - 16'h0001;
        end
      end
    endcase
  end

  // Sequencer registers
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      state_reg <= RUNNING;
      hold_count_reg <= 16'h0000;
    end else begin
      state_reg <= state_next;
      hold_count_reg <= hold_count_next;
    end
  end

  // Control bits: hardware reset and the trigger both restore defaults
  always_ff @(posedge mclk) begin
    if (sys_rst || reset_trigger) begin
      pin_low_power_request_enable_reg <= GCTL_DEFAULT[`GCTL_PIN_ENABLE_BIT];
      squelch_kind_reg <= GCTL_DEFAULT[`GCTL_SQUELCH_BIT];
      register_low_power_request_reg <= GCTL_DEFAULT[`GCTL_SW_LOW_POWER_BIT];
    end else if (gctl_write) begin
      pin_low_power_request_enable_reg <= host_access.wdata[`GCTL_PIN_ENABLE_BIT];
      squelch_kind_reg <= host_access.wdata[`GCTL_SQUELCH_BIT];
      register_low_power_request_reg <= host_access.wdata[`GCTL_SW_LOW_POWER_BIT];
    end
  end

  // High byte read freezes the low byte of the same pair
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      lsb_hold_reg <= 8'h00;
      hold_index_reg <= 3'h0;
      hold_valid_reg <= 1'b0;
    end else if (host_access.rd && in_monitors) begin
      lsb_hold_reg <= mon_word[7:0];
      hold_index_reg <= mon_index;
      hold_valid_reg <= is_high_byte;
    end
  end

  // Read answer, one cycle after the strobe
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      host_rdata_reg <= 8'h00;
      host_rvalid_reg <= 1'b0;
      host_hit_reg <= 1'b0;
    end else begin
      host_rdata_reg <= host_access.rd ? rdata_next : 8'h00;
      host_rvalid_reg <= host_access.rd;
      host_hit_reg <= (host_access.rd || host_access.wr) && in_bank;
    end
  end

  // Module-facing outputs
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      low_power_request_reg <= 1'b0;
      squelch_kind_select_reg <= 1'b0;
      module_reset_reg <= 1'b1;
    end else begin
      low_power_request_reg <= lp_next;
      squelch_kind_select_reg <= squelch_kind_reg;
      module_reset_reg <= state_next == SOFT_RESET;
    end
  end

  assign host_rdata = host_rdata_reg;
  assign host_rvalid = host_rvalid_reg;
  assign host_hit = host_hit_reg;
  assign low_power_request = low_power_request_reg;
  assign squelch_kind_select = squelch_kind_select_reg;
  assign module_reset = module_reset_reg;

  // Length of each software reset pulse, for checking only
  logic [15:0] pulse_len_reg;
  always_ff @(posedge mclk) begin
    if (sys_rst || !module_reset_reg) begin
      pulse_len_reg <= 16'h0000;
    end else begin
      pulse_len_reg <= pulse_len_reg + 16'h0001;
    end
  end

  // Temperature word follows its sample
  a_temp_capture: assert property (@(posedge mclk) disable iff (sys_rst)
    samples_valid |=> mon_reg[0] == $past(samples.temperature))
    else $error("temperature word did not follow its sample");

  // Supply word follows its sample
  a_supply_capture: assert property (@(posedge mclk) disable iff (sys_rst)
    samples_valid |=> mon_reg[1] == $past(samples.supply))
    else $error("supply word did not follow its sample");

  // Aux one source matches its advertisement
  a_aux_one_source: assert property (@(posedge mclk) disable iff (sys_rst)
    samples_valid |=> mon_reg[2] == (AUX_ONE_IS_TEC ? $past(tec_code) : $past(samples.aux_custom)))
    else $error("aux one carries the wrong observable");

  // Aux two source matches its advertisement
  a_aux_two_source: assert property (@(posedge mclk) disable iff (sys_rst)
    samples_valid |=> mon_reg[3] == (AUX_TWO_IS_TEC ? $past(tec_code) : $past(samples.laser_temperature)))
    else $error("aux two carries the wrong observable");

  // Aux three source matches its advertisement
  a_aux_three_source: assert property (@(posedge mclk) disable iff (sys_rst)
    samples_valid |=> mon_reg[4] == (AUX_THREE_IS_SUPPLY ? $past(samples.aux_supply) :
                                     $past(samples.laser_temperature)))
    else $error("aux three carries the wrong observable");

  // Cooler current never reads below full cooling
  a_tec_symmetric: assert property (@(posedge mclk) disable iff (sys_rst)
    (samples_valid && samples.tec_current == `TEC_MOST_NEGATIVE && (AUX_ONE_IS_TEC || AUX_TWO_IS_TEC))
      |=> ((!AUX_ONE_IS_TEC || mon_reg[2] == `TEC_FULL_COOLING) &&
           (!AUX_TWO_IS_TEC || mon_reg[3] == `TEC_FULL_COOLING)))
    else $error("cooler current left the symmetric range");

  // Vendor word is passed bit for bit
  a_vendor_passthru: assert property (@(posedge mclk) disable iff (sys_rst)
    samples_valid |=> mon_reg[5] == $past(samples.vendor))
    else $error("vendor word altered");

  // Disabled pin and no register request give no low power request
  a_pin_ignored: assert property (@(posedge mclk) disable iff (sys_rst)
    (!pin_low_power_request_enable_reg && !register_low_power_request_reg) |=> !low_power_request)
    else $error("low power pin not ignored");

  // Enabled pin raises the request next cycle
  a_pin_honoured: assert property (@(posedge mclk) disable iff (sys_rst)
    (pin_low_power_request_enable_reg && pin_low_power_request) |=> low_power_request)
    else $error("low power pin not honoured");

  // Squelch output follows a plain control write two cycles later
  a_squelch_write: assert property (@(posedge mclk) disable iff (sys_rst)
    (gctl_write && !reset_trigger) |-> ##2 squelch_kind_select == $past(host_access.wdata[`GCTL_SQUELCH_BIT], 2))
    else $error("squelch kind did not follow the write");

  // Hardware reset leaves the enable set and the request clear
  a_reset_defaults: assert property (@(posedge mclk)
    sys_rst |=> (pin_low_power_request_enable_reg && !register_low_power_request_reg && !squelch_kind_reg))
    else $error("control defaults wrong after reset");

  // Trigger bit always reads back as zero
  a_trigger_reads_zero: assert property (@(posedge mclk) disable iff (sys_rst)
    (host_access.rd && is_gctl) |=> !host_rdata[`GCTL_SW_RESET_BIT])
    else $error("reset trigger bit read as one");

  // Software reset pulse lasts exactly the hold time; the pulse that ends a hardware reset is not counted
  a_reset_hold: assert property (@(posedge mclk) disable iff (sys_rst)
    ($fell(module_reset) && !$past(sys_rst, 2)) |-> $past(pulse_len_reg) == 16'(RESET_HOLD_CYCLES - 1))
    else $error("software reset pulse has the wrong length");

  // Low byte right after a high byte read comes from the frozen sample
  a_pair_coherent: assert property (@(posedge mclk) disable iff (sys_rst)
    (host_access.rd && in_monitors && use_hold) |=> host_rdata == $past(lsb_hold_reg))
    else $error("pair read not coherent");

  // A trigger write restores the defaults and raises the module reset
  a_trigger_restores: assert property (@(posedge mclk) disable iff (sys_rst)
    reset_trigger |=> (module_reset && pin_low_power_request_enable_reg && !squelch_kind_reg &&
                       !register_low_power_request_reg))
    else $error("software reset trigger did not restore the defaults");

  // Writing zero to the trigger bit leaves the module running
  a_trigger_zero_idle: assert property (@(posedge mclk) disable iff (sys_rst)
    (host_access.wr && is_gctl && !host_access.wdata[`GCTL_SW_RESET_BIT] && state_reg == RUNNING)
      |=> !module_reset)
    else $error("writing zero to the trigger reset the module");

  // Control writes during the software reset hold are refused
  a_write_refused: assert property (@(posedge mclk) disable iff (sys_rst)
    (host_access.wr && is_gctl && state_reg == SOFT_RESET) |=> ($stable(pin_low_power_request_enable_reg) &&
      $stable(squelch_kind_reg) && $stable(register_low_power_request_reg)))
    else $error("control write landed during the software reset hold");

  // Software reset pulse never outlasts the hold time
  a_pulse_bounded: assert property (@(posedge mclk) disable iff (sys_rst)
    pulse_len_reg <= 16'(RESET_HOLD_CYCLES))
    else $error("software reset pulse outlasted the hold time");

  // Software request alone raises the low power request
  a_sw_request: assert property (@(posedge mclk) disable iff (sys_rst)
    register_low_power_request_reg |=> low_power_request)
    else $error("software low power request not passed on");

  // Pin enable bit follows a plain control write
  a_enable_write: assert property (@(posedge mclk) disable iff (sys_rst)
    (gctl_write && !reset_trigger) |=>
      pin_low_power_request_enable_reg == $past(host_access.wdata[`GCTL_PIN_ENABLE_BIT]))
    else $error("pin enable did not follow the write");

  // High byte read answers from the live word and freezes its low byte
  a_high_byte_read: assert property (@(posedge mclk) disable iff (sys_rst)
    (host_access.rd && in_monitors && is_high_byte) |=> (host_rdata == $past(mon_word[15:8]) &&
      hold_valid_reg && lsb_hold_reg == $past(mon_word[7:0])))
    else $error("high byte read did not freeze its pair");

endmodule // module_monitor_control_regs

/* module_monitor_control_regs_tb.sv */
// Self-checking bench for the monitor values and global control byte.
// Assumes the host model above and a short software reset hold set here.
`include "module_monitor_cfg.svh"

module module_monitor_control_regs_tb
  import module_monitor_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int HOLD = 4; // Shortened software reset hold
  localparam int LIMIT = 5000; // Cycle ceiling for the whole run

  logic mclk, sys_rst, host_rvalid, host_hit, samples_valid, pin_low_power_request;
  logic low_power_request, squelch_kind_select, module_reset, v, h;
  host_access_t host_access; // Byte request from the host model
  monitor_samples_t samples, cur; // Driven samples and last captured set
  logic [7:0] host_rdata, q, rdata_alt;
  logic [15:0] e, e2;
  logic [2:0] f;
  logic [7:0] addrs [6] = '{8'h0d, 8'h1b, 8'h1c, 8'h1d, 8'h1e, 8'h1f};
  int n_fail, num_checks, cycles, n;

  // Aux one carries cooler current, aux two laser temperature, aux three extra supply
  module_monitor_control_regs #(.AUX_ONE_IS_TEC(1'b1), .AUX_TWO_IS_TEC(1'b0),
    .AUX_THREE_IS_SUPPLY(1'b1), .VENDOR_IS_SIGNED(1'b0), .RESET_HOLD_CYCLES(HOLD)) dut (
    .mclk(mclk), .sys_rst(sys_rst), .host_access(host_access), .host_rdata(host_rdata),
    .host_rvalid(host_rvalid), .host_hit(host_hit), .samples(samples), .samples_valid(samples_valid),
    .pin_low_power_request(pin_low_power_request), .low_power_request(low_power_request),
    .squelch_kind_select(squelch_kind_select), .module_reset(module_reset));

  // Second build: aux one custom, aux two cooler current, aux three laser temperature
  module_monitor_control_regs #(.AUX_ONE_IS_TEC(1'b0), .AUX_TWO_IS_TEC(1'b1),
    .AUX_THREE_IS_SUPPLY(1'b0), .VENDOR_IS_SIGNED(1'b1), .RESET_HOLD_CYCLES(HOLD)) dut_alt (
    .mclk(mclk), .sys_rst(sys_rst), .host_access(host_access), .host_rdata(rdata_alt),
    .host_rvalid(), .host_hit(), .samples(samples), .samples_valid(samples_valid),
    .pin_low_power_request(pin_low_power_request), .low_power_request(),
    .squelch_kind_select(), .module_reset());

  host_port_model host (.mclk(mclk), .host_access(host_access), .host_rdata(host_rdata),
    .host_rvalid(host_rvalid), .host_hit(host_hit));

  // 50 MHz clock
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  // Hang guard
  always @(posedge mclk) begin
    cycles++;
    if (cycles == LIMIT) begin
      n_fail++;
      end_of_test();
    end
  end

  // Compare and count
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  // Verdict and end of run
  task automatic end_of_test();
    if (n_fail == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // Bus helpers; an idle bus shows changing junk
  task automatic rd(input logic [7:0] a);
    host.acc(1'b1, 1'b0, a, 8'($urandom), q, v, h);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    host.acc(1'b0, 1'b1, a, d, q, v, h);
  endtask
  task automatic idle(input int k);
    repeat (k) host.acc(1'b0, 1'b0, 8'($urandom), 8'($urandom), q, v, h);
  endtask

  // Fresh random sample set, optionally with the most negative cooler code
  task automatic new_samples(input bit corner);
    samples = {16'($urandom), 16'($urandom), 16'($urandom), 16'($urandom),
               16'($urandom), 16'($urandom), 16'($urandom)};
    if (corner) samples.tec_current = `TEC_MOST_NEGATIVE;
    samples_valid = 1'b1;
    idle(1);
    samples_valid = 1'b0;
    cur = samples;
  endtask

  // Word expected in monitor pair i for the main build or the second build
  function automatic logic [15:0] sample_word(int i, monitor_samples_t s, bit alt);
    logic [15:0] tec;
    tec = (s.tec_current === `TEC_MOST_NEGATIVE) ? `TEC_FULL_COOLING : s.tec_current;
    case (i)
      0: return s.temperature;
      1: return s.supply;
      2: return alt ? s.aux_custom : tec;
      3: return alt ? tec : s.laser_temperature;
      4: return alt ? s.laser_temperature : s.aux_supply;
      default: return s.vendor;
    endcase
  endfunction

  // Main sequence
  initial begin
    sys_rst = 1'b1;
    samples = '0;
    samples_valid = 1'b0;
    pin_low_power_request = 1'b0;
    void'($urandom(96));
    repeat (6) @(negedge mclk);
    sys_rst = 1'b0;
    idle(1);
    // Defaults and pin gating
    rd(`OFS_GLOBAL_CONTROL);
    chk({v, h, q}, {2'b11, `GCTL_RESET_VALUE}, "control default");
    pin_low_power_request = 1'b1;
    idle(2);
    chk({low_power_request, squelch_kind_select, module_reset}, 3'b100, "pin honoured");
    pin_low_power_request = 1'b0;
    idle(2);
    chk(low_power_request, 1'b0, "pin released");
    // Monitor pairs, high then low with a newer sample in between
    for (int r = 0; r < 4; r++) begin
      new_samples(r == 0);
      for (int i = 0; i < 6; i++) begin
        e = sample_word(i, cur, 1'b0);
        e2 = sample_word(i, cur, 1'b1);
        rd(8'h0e + 8'(2 * i));
        chk({v, h, q}, {2'b11, e[15:8]}, "monitor high");
        chk(rdata_alt, e2[15:8], "alt monitor high");
        new_samples(r == 1);
        rd(8'h0f + 8'(2 * i));
        chk({v, h, q}, {2'b11, e[7:0]}, "monitor low");
        chk(rdata_alt, e2[7:0], "alt monitor low");
      end
    end
    rd(8'h0f);
    chk(q, cur.temperature[7:0], "live low");
    wr(`OFS_TEMPERATURE, 8'hff);
    rd(`OFS_TEMPERATURE);
    chk(q, cur.temperature[15:8], "read only");
    // Reserved and out of range places
    for (int k = 0; k < 6; k++) begin
      rd(addrs[k]);
      chk({v, h, q}, {1'b1, addrs[k] inside {[8'h0e:8'h1e]}, 8'h00}, "reserved");
    end
    // Every combination of the three control bits
    for (int k = 0; k < 16; k++) begin
      f = 3'(k);
      pin_low_power_request = 1'($urandom);
      wr(`OFS_GLOBAL_CONTROL, {1'b0, f, 1'b0, 3'($urandom)});
      rd(`OFS_GLOBAL_CONTROL);
      chk(q, {1'b0, f, 4'h0}, "control readback");
      idle(1);
      chk(squelch_kind_select, f[1], "squelch");
      chk(low_power_request, (f[2] & pin_low_power_request) | f[0], "low power");
    end
    // Software reset with a write refused during its hold
    wr(`OFS_GLOBAL_CONTROL, 8'h38);
    chk(module_reset, 1'b1, "soft reset start");
    n = 1;
    wr(`OFS_GLOBAL_CONTROL, 8'h20);
    while (module_reset === 1'b1 && n < 100) begin
      idle(1);
      n++;
    end
    chk(16'(n), 16'(HOLD), "soft reset hold");
    rd(`OFS_GLOBAL_CONTROL);
    chk(q, `GCTL_RESET_VALUE, "after soft reset");
    // Hardware reset in mid-run gives the same defaults
    wr(`OFS_GLOBAL_CONTROL, 8'h30);
    sys_rst = 1'b1;
    idle(1);
    chk(module_reset, 1'b1, "hard reset");
    sys_rst = 1'b0;
    idle(1);
    rd(`OFS_GLOBAL_CONTROL);
    chk(q, `GCTL_RESET_VALUE, "after hard reset");
    end_of_test();
  end
endmodule // module_monitor_control_regs_tb

/* module_monitor_pkg.sv */
// Types shared by the module monitor and control bank.
// Assumes the constants header is included by the design files that need numbers.
package module_monitor_pkg;

  // One byte access from the two-wire engine, strobes last one cycle
  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } host_access_t;

  // Raw samples delivered by the measurement front end
  typedef struct packed {
    logic [15:0] temperature;
    logic [15:0] supply;
    logic [15:0] aux_custom;
    logic [15:0] tec_current;
    logic [15:0] laser_temperature;
    logic [15:0] aux_supply;
    logic [15:0] vendor;
  } monitor_samples_t;

  // Software reset sequencer states
  typedef enum logic {RUNNING, SOFT_RESET} reset_state_t;

endpackage
